//--- bench/dae_far_model.sv
// Sensor front end and pulled-up alarm lines facing the detector
`timescale 1ns/10ps

module dae_far_model (
  // Clock
  input  wire logic         clk,
  // Samples
  output logic              sample_valid,
  output dae_pkg::dae_src_t src_raw,
  output dae_pkg::dae_src_t src_filt,
  // Alarm lines
  input  wire logic         first_o,
  input  wire logic         first_oe,
  input  wire logic         second_o,
  input  wire logic         second_oe,
  output logic              line_first,
  output logic              line_second
);
  import dae_pkg::*;

  // Undriven lines float to the pull-up level
  assign line_first  = first_oe ? first_o : 1'b1;
  assign line_second = second_oe ? second_o : 1'b1;

  initial begin
    sample_valid = 1'b0;
    src_raw      = '0;
    src_filt     = '0;
  end

  // One-cycle sample, then scrambled data so a stale value is never reused
  task automatic send(input dae_src_t r, input dae_src_t f);
    @(posedge clk);
    sample_valid <= 1'b1;
    src_raw      <= r;
    src_filt     <= f;
    @(posedge clk);
    sample_valid <= 1'b0;
    src_raw      <= ~r;
    src_filt     <= ~f;
  endtask
endmodule // dae_far_model

//--- bench/dual_alarm_event_detector_test.sv
// Self-checking regression of the dual alarm detector
`timescale 1ns/10ps

module dual_alarm_event_detector_test;
  import dae_pkg::*;

  logic         clk;
  logic         rst;
  dae_reg_req_t req;
  logic [15:0]  reg_rdata;
  logic         sample_valid;
  dae_src_t     src_raw;
  dae_src_t     src_filt;
  logic         o1, oe1, o2, oe2, line1, line2;
  dae_src_t     s;
  dae_src_t     f;
  logic [15:0]  ctl;
  logic [15:0]  ex;
  int           bad_count = 0;
  int           checks = 0;
  logic [6:0]   ofs[4] = '{7'h22, 7'h24, 7'h26, 7'h28};
  logic [15:0]  msk[4] = '{16'hBFFF, 16'h00FF, 16'h00FF, 16'hFF17};

  dae_detector dut_u (.clk(clk), .rst(rst), .req(req), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .src_raw(src_raw), .src_filt(src_filt), .io_line_first_o(o1), .io_line_first_oe(oe1),
    .io_line_second_o(o2), .io_line_second_oe(oe2));

  dae_far_model far_u (.clk(clk), .sample_valid(sample_valid), .src_raw(src_raw), .src_filt(src_filt),
    .first_o(o1), .first_oe(oe1), .second_o(o2), .second_oe(oe2), .line_first(line1), .line_second(line2));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask

  // Pins settle within two cycles of a flag or control change
  task automatic pins(input logic e1, input logic e2);
    repeat (3) @(posedge clk);
    #1;
    check("line_first", {15'h0, line1}, {15'h0, e1});
    check("line_second", {15'h0, line2}, {15'h0, e2});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs[i]) begin
      rdchk(ofs[i], 16'h0000, "reset value");
      wr(ofs[i], 16'hFFFF);
      rdchk(ofs[i], msk[i], "write mask");
      wr(ofs[i], 16'h0000);
    end
    rdchk(7'h30, 16'h0000, "unmapped");
    $display("test registers done");
    // Alarm 2 static on gyro, active high on first line
    wr(7'h22, 16'h800A);
    wr(7'h28, 16'h2006);
    pins(1'b0, 1'b1);
    s = '0;
    s.gyro = 14'd20;
    far_u.send(s, s);
    pins(1'b1, 1'b1);
    rdchk(7'h3C, 16'h0200, "greater");
    rdchk(7'h3C, 16'h0000, "cleared");
    wr(7'h22, 16'h000A);
    s.gyro = 14'h3FFB;
    far_u.send(s, s);
    rdchk(7'h3C, 16'h0200, "signed less");
    s.gyro = 14'd20;
    far_u.send(s, s);
    rdchk(7'h3C, 16'h0000, "not less");
    wr(7'h28, 16'h2016);
    f = s;
    s.gyro = 14'h3FFB;
    far_u.send(s, f);
    rdchk(7'h3C, 16'h0000, "filtered");
    far_u.send(f, s);
    rdchk(7'h3C, 16'h0200, "filtered");
    wr(7'h28, 16'h2005);
    far_u.send(f, f);
    pins(1'b1, 1'b1);
    far_u.send(s, s);
    pins(1'b1, 1'b0);
    rdchk(7'h3C, 16'h0200, "low second");
    $display("test static done");
    // Every source code for both alarms
    wr(7'h20, 16'h8000);
    wr(7'h22, 16'h8000);
    s = {14'd5, 14'd5, 14'd5, 14'd5};
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 8; c++) begin
        ctl = 16'h0006 | (16'(c) << (8 + 4 * k));
        ex = (c == 1 || c == 2 || c == 5 || c == 6) ? (16'h0100 << k) : 16'h0000;
        wr(7'h28, ctl);
        far_u.send(s, s);
        pins(ex != 16'h0000, 1'b1);
        rdchk(7'h3C, ex, "source code");
      end
    end
    $display("test sources done");
    // Rate of change over two deltas, each alarm in turn
    for (int k = 0; k < 2; k++) begin
      wr(7'h20 + 7'(2 * k), 16'h8003);
      wr(7'h24 + 7'(2 * k), 16'h0002);
      wr(7'h28, 16'h0900 << (4 * k));
      for (int i = 0; i < 3; i++) begin
        s.supply = 14'(100 + 5 * i);
        far_u.send(s, s);
        rdchk(7'h3C, (i == 2) ? (16'h0100 << k) : 16'h0000, "rate");
      end
    end
    // Rising gyro against a negative greater-than rate threshold
    wr(7'h22, 16'hBFFD);
    wr(7'h28, 16'hA000);
    for (int i = 0; i < 3; i++) begin
      s.gyro = 14'(100 + 5 * i);
      far_u.send(s, s);
      rdchk(7'h3C, (i == 2) ? 16'h0200 : 16'h0000, "signed rate");
    end
    $display("test rate done");
    final_report();
  end
endmodule // dual_alarm_event_detector_test

//--- hw/dae_detector.sv
// Dual alarm event detector: configuration registers, comparison and alarm pin
//
// Operation
// - Alarm-2 threshold bit 15 picks greater-than (1) or less-than (0); bit 14 unused.
// - Alarm-2 threshold bits 13:0 take the number format of the selected source.
// - Alarm-1 sample count is 8-bit unsigned in bits 7:0, resets to zero.
// - Alarm-2 sample count is 8-bit unsigned in bits 7:0, resets to zero.
// - Control bit 15 picks rate-of-change (1) or static level (0) for alarm 2.
// - Control bit 11 picks rate-of-change (1) or static level (0) for alarm 1.
// - Control bits 14:12 pick alarm-2 source; 000 off, 011/100/111 inactive.
// - Control bits 10:8 pick alarm-1 source with the same coding.
// - Control bit 4 picks filtered (1) or unfiltered (0) source data.
// - Control bit 2 enables alarm pin, bit 1 polarity, bit 0 second line.
// - Rate mode averages consecutive sample differences over the count, then compares.
// - A satisfied comparison sets the matching alarm flag.
// - Alarm flags stay set until a status read, which clears them.
`timescale 1ns/10ps
`include "dae_map.svh"

module dae_detector (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register access
  input  wire dae_pkg::dae_reg_req_t req,
  output logic [15:0]            reg_rdata,
  // Source samples
  input  wire logic              sample_valid,
  input  wire dae_pkg::dae_src_t src_raw,
  input  wire dae_pkg::dae_src_t src_filt,
  // Alarm lines
  output logic                   io_line_first_o,
  output logic                   io_line_first_oe,
  output logic                   io_line_second_o,
  output logic                   io_line_second_oe
);
  import dae_pkg::*;

  dae_state_t               s;
  dae_state_t               n;
  dae_src_t                 sel;
  logic [1:0][2:0]          code;
  logic [1:0]               rate_of_change_mode;
  logic [1:0][15:0]         thr;
  logic [1:0][7:0]          nlim;
  logic [1:0]               ok;
  logic [1:0][15:0]         cur;
  logic [1:0][15:0]         mag;
  logic [1:0]               hit;
  logic                     clear;
  logic                     cfg_wr;
  logic                     act;

  function automatic logic src_ok(input logic [2:0] c);
    case (c)
      DAE_SRC_SUPPLY, DAE_SRC_GYRO, DAE_SRC_AUX, DAE_SRC_TEMP: src_ok = 1'b1;
      default: src_ok = 1'b0;
    endcase
  endfunction

  function automatic logic src_signed(input logic [2:0] c);
    src_signed = (c == DAE_SRC_GYRO) || (c == DAE_SRC_TEMP);
  endfunction

  // Source sample widened to 16 bits in its own number format
  function automatic logic [15:0] pick(input logic [2:0] c, input dae_src_t d);
    case (c)
      DAE_SRC_SUPPLY: pick = {2'h0, d.supply};
      DAE_SRC_GYRO:   pick = {{2{d.gyro[13]}}, d.gyro};
      DAE_SRC_AUX:    pick = {2'h0, d.aux};
      DAE_SRC_TEMP:   pick = {{2{d.temp[13]}}, d.temp};
      default:        pick = 16'h0000;
    endcase
  endfunction

  // Threshold magnitude read in the same format as the source
  function automatic logic [15:0] ext_mag(input logic [2:0] c, input logic [15:0] t);
    if (src_signed(c)) begin
      ext_mag = {{2{t[`DAE_THR_MAG_MSB]}}, t[`DAE_THR_MAG_MSB:0]};
    end else begin
      ext_mag = {2'h0, t[`DAE_THR_MAG_MSB:0]};
    end
  endfunction

  assign sel    = s.ctrl[`DAE_CTRL_FILT] ? src_filt : src_raw;
  assign clear  = req.rd && (req.addr == `DAE_OFS_STATUS);
  assign cfg_wr = req.wr && ((req.addr == `DAE_OFS_CTRL) || (req.addr == `DAE_OFS_SMPL1)
                             || (req.addr == `DAE_OFS_SMPL2));

  // Per-alarm view of the configuration
  assign code[0] = s.ctrl[`DAE_CTRL_SRC1_H:`DAE_CTRL_SRC1_L];
  assign code[1] = s.ctrl[`DAE_CTRL_SRC2_H:`DAE_CTRL_SRC2_L];
  assign rate_of_change_mode[0]  = s.ctrl[`DAE_CTRL_ROC1];
  assign rate_of_change_mode[1]  = s.ctrl[`DAE_CTRL_ROC2];
  assign thr[0]  = s.thr1;
  assign thr[1]  = s.thr2;
  assign nlim[0] = (s.smpl1[7:0] == 8'h00) ? 8'h01 : s.smpl1[7:0];
  assign nlim[1] = (s.smpl2[7:0] == 8'h00) ? 8'h01 : s.smpl2[7:0];

  generate
    for (genvar g = 0; g < 2; g++) begin : g_view
      assign ok[g]  = src_ok(code[g]);
      assign cur[g] = pick(code[g], sel);
      assign mag[g] = ext_mag(code[g], thr[g]);
    end
  endgenerate

  always_comb begin
    logic [16:0]        diff;
    logic signed [23:0] sum;
    logic signed [24:0] lim;
    logic [8:0]         cnt1;
    logic               gt;
    logic               sgn;
    diff = 17'h00000;
    sum  = 24'sh000000;
    lim  = 25'sh0000000;
    cnt1 = 9'h000;
    gt   = 1'b0;
    sgn  = 1'b0;
    n    = s;
    hit  = 2'h0;

    // Register writes keep only implemented bits
    if (req.wr) begin
      case (req.addr)
        `DAE_OFS_THR1:  n.thr1  = req.wdata & `DAE_THR_MASK;
        `DAE_OFS_THR2:  n.thr2  = req.wdata & `DAE_THR_MASK;
        `DAE_OFS_SMPL1: n.smpl1 = req.wdata & `DAE_SMPL_MASK;
        `DAE_OFS_SMPL2: n.smpl2 = req.wdata & `DAE_SMPL_MASK;
        `DAE_OFS_CTRL:  n.ctrl  = req.wdata & `DAE_CTRL_MASK;
        default: ;
      endcase
    end

    // Read data, unmapped offsets answer zero
    case (req.addr)
      `DAE_OFS_THR1:   n.rdata = s.thr1;
      `DAE_OFS_THR2:   n.rdata = s.thr2;
      `DAE_OFS_SMPL1:  n.rdata = s.smpl1;
      `DAE_OFS_SMPL2:  n.rdata = s.smpl2;
      `DAE_OFS_CTRL:   n.rdata = s.ctrl;
      `DAE_OFS_STATUS: n.rdata = {6'h00, s.flags, 8'h00};
      default:         n.rdata = 16'h0000;
    endcase
    if (!req.rd) begin
      n.rdata = s.rdata;
    end

    for (int i = 0; i < 2; i++) begin
      gt  = thr[i][`DAE_THR_DIR_BIT];
      sgn = src_signed(code[i]);
      if (!ok[i] || cfg_wr) begin
        // Stale history would give a false delta after a change
        n.alm[i] = '0;
      end else if (sample_valid) begin
        n.alm[i].prev      = cur[i];
        n.alm[i].have_prev = 1'b1;
        if (!rate_of_change_mode[i]) begin
          if (sgn) begin
            hit[i] = gt ? ($signed(cur[i]) > $signed(mag[i])) : ($signed(cur[i]) < $signed(mag[i]));
          end else begin
            hit[i] = gt ? (cur[i] > mag[i]) : (cur[i] < mag[i]);
          end
        end else if (s.alm[i].have_prev) begin
          // Sum of deltas against threshold times count avoids a divider
          diff = {sgn & cur[i][15], cur[i]} - {sgn & s.alm[i].prev[15], s.alm[i].prev};
          sum  = $signed(s.alm[i].acc) + $signed({{7{diff[16]}}, diff});
          cnt1 = {1'b0, s.alm[i].cnt} + 9'h001;
          if (cnt1 >= {1'b0, nlim[i]}) begin
            lim    = $signed(mag[i]) * $signed({1'b0, nlim[i]});
            hit[i] = gt ? ($signed({sum[23], sum}) > lim) : ($signed({sum[23], sum}) < lim);
            n.alm[i].acc = 24'h000000;
            n.alm[i].cnt = 8'h00;
          end else begin
            n.alm[i].acc = sum;
            n.alm[i].cnt = cnt1[7:0];
          end
        end
      end
      // New event wins over the read that clears
      n.flags[i] = (clear ? 1'b0 : s.flags[i]) | hit[i];
    end

    // Alarm pin follows enabled flags with programmed polarity and line
    act     = |(s.flags & ok);
    n.pin_o = s.ctrl[`DAE_CTRL_OUT_HI] ? act : ~act;
    n.oe1   = s.ctrl[`DAE_CTRL_OUT_EN] & ~s.ctrl[`DAE_CTRL_OUT_L2];
    n.oe2   = s.ctrl[`DAE_CTRL_OUT_EN] & s.ctrl[`DAE_CTRL_OUT_L2];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata         = s.rdata;
  assign io_line_first_o   = s.pin_o;
  assign io_line_second_o  = s.pin_o;
  assign io_line_first_oe  = s.oe1;
  assign io_line_second_oe = s.oe2;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_thr_unused;
    s.thr2[14] == 1'b0 && s.thr1[14] == 1'b0;
  endproperty
  a_thr_unused: assert property (p_thr_unused)
    else $error("threshold bit 14 not zero");

  property p_thr_write;
    (req.wr && req.addr == `DAE_OFS_THR2) |=> s.thr2[13:0] == $past(req.wdata[13:0])
      && s.thr2[15] == $past(req.wdata[15]);
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("threshold write lost");

  property p_smpl1;
    s.smpl1[15:8] == 8'h00 && ($past(rst) -> s.smpl1 == 16'h0000);
  endproperty
  a_smpl1: assert property (p_smpl1)
    else $error("sample count 1 wrong");

  property p_smpl2;
    (req.wr && req.addr == `DAE_OFS_SMPL2) |=> s.smpl2 == {8'h00, $past(req.wdata[7:0])};
  endproperty
  a_smpl2: assert property (p_smpl2)
    else $error("sample count 2 wrong");

  property p_static_gt;
    (sample_valid && ok[1] && !cfg_wr && !s.ctrl[15] && s.thr2[15] && !src_signed(code[1])
      && cur[1] > mag[1]) |-> hit[1] ##1 s.flags[1];
  endproperty
  a_static_gt: assert property (p_static_gt)
    else $error("static greater-than missed");

  property p_roc_count;
    (sample_valid && ok[0] && !cfg_wr && rate_of_change_mode[0] && s.alm[0].have_prev
      && ({1'b0, s.alm[0].cnt} + 9'h001) < {1'b0, nlim[0]}) |=> s.alm[0].cnt == $past(s.alm[0].cnt) + 8'h01;
  endproperty
  a_roc_count: assert property (p_roc_count)
    else $error("delta count did not advance");

  property p_off_silent;
    !ok[1] |-> !hit[1] && s.alm[1].have_prev == 1'b0 ##1 !hit[1];
  endproperty
  a_off_silent: assert property (p_off_silent)
    else $error("inactive alarm 2 fired");

  property p_off_silent1;
    !ok[0] |-> !hit[0];
  endproperty
  a_off_silent1: assert property (p_off_silent1)
    else $error("inactive alarm 1 fired");

  property p_filt;
    s.ctrl[4] |-> cur[0] == pick(code[0], src_filt);
  endproperty
  a_filt: assert property (p_filt)
    else $error("filtered data not used");

  property p_pin_off;
    !s.ctrl[2] |=> !io_line_first_oe && !io_line_second_oe;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("alarm pin driven while disabled");

  property p_flag_set;
    hit[0] |=> s.flags[0] ##1 (s.flags[0] || $past(clear));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("alarm flag not kept");

  property p_read_clear;
    clear |=> s.flags == $past(hit);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear");

  property p_idle_level;
    s.flags == 2'h0 |=> io_line_first_o == !$past(s.ctrl[`DAE_CTRL_OUT_HI]);
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("idle alarm level wrong");

  property p_inactive_pin;
    !ok[0] && !ok[1] |=> io_line_second_o == !$past(s.ctrl[`DAE_CTRL_OUT_HI]);
  endproperty
  a_inactive_pin: assert property (p_inactive_pin)
    else $error("inactive alarms drove the pin");

  property p_status_read;
    clear |=> reg_rdata == {6'h00, $past(s.flags), 8'h00};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read data wrong");

  property p_reset_cfg;
    $past(rst) |-> s.ctrl == `DAE_RST_REG && s.thr2 == `DAE_RST_REG && s.smpl2 == `DAE_RST_REG;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg)
    else $error("configuration not zero after reset");

endmodule // dae_detector

//--- hw/dae_map.svh
// Register offsets, field positions and reset values of the dual alarm detector
`ifndef DAE_MAP_SVH
`define DAE_MAP_SVH

`define DAE_OFS_THR1    7'h20
`define DAE_OFS_THR2    7'h22
`define DAE_OFS_SMPL1   7'h24
`define DAE_OFS_SMPL2   7'h26
`define DAE_OFS_CTRL    7'h28
`define DAE_OFS_STATUS  7'h3C

`define DAE_RST_REG     16'h0000

`define DAE_THR_DIR_BIT 15
`define DAE_THR_MAG_MSB 13
`define DAE_THR_MASK    16'hBFFF
`define DAE_SMPL_MASK   16'h00FF
`define DAE_CTRL_MASK   16'hFF17

`define DAE_CTRL_ROC2   15
`define DAE_CTRL_SRC2_H 14
`define DAE_CTRL_SRC2_L 12
`define DAE_CTRL_ROC1   11
`define DAE_CTRL_SRC1_H 10
`define DAE_CTRL_SRC1_L 8
`define DAE_CTRL_FILT   4
`define DAE_CTRL_OUT_EN 2
`define DAE_CTRL_OUT_HI 1
`define DAE_CTRL_OUT_L2 0

`define DAE_STAT_ALM1   8

`endif

//--- hw/dae_pkg.sv
// Types shared by the dual alarm detector
package dae_pkg;

  typedef enum logic [2:0] {
    DAE_SRC_OFF    = 3'h0,
    DAE_SRC_SUPPLY = 3'h1,
    DAE_SRC_GYRO   = 3'h2,
    DAE_SRC_AUX    = 3'h5,
    DAE_SRC_TEMP   = 3'h6
  } dae_src_code_t;

  typedef struct packed {
    logic [13:0] supply;
    logic [13:0] gyro;
    logic [13:0] aux;
    logic [13:0] temp;
  } dae_src_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } dae_reg_req_t;

  typedef struct packed {
    logic [15:0] prev;
    logic        have_prev;
    logic [23:0] acc;
    logic [7:0]  cnt;
  } dae_alarm_t;

  typedef struct packed {
    logic [15:0]           thr1;
    logic [15:0]           thr2;
    logic [15:0]           smpl1;
    logic [15:0]           smpl2;
    logic [15:0]           ctrl;
    dae_alarm_t [1:0]      alm;
    logic [1:0]            flags;
    logic [15:0]           rdata;
    logic                  pin_o;
    logic                  oe1;
    logic                  oe2;
  } dae_state_t;

endpackage
